// *** adcr_pkg.sv ***
// constants and types shared by the converter readout control
`default_nettype none

package adcr_pkg;

	// conversion geometry
	localparam int RES_BITS = 12;
	localparam int CONV_CYCLES = 12;
	localparam int NULL_BITS = 1;
	localparam int FIFO_DEPTH = 16;

	// shift clock falling edges counted from the select falling edge
	localparam int EDGE_HOLD = 1;
	localparam int EDGE_LAST_MSB = EDGE_HOLD + CONV_CYCLES;
	localparam int EDGE_LAST_LSB = EDGE_LAST_MSB + RES_BITS - 1;
	localparam int MIN_SEL_LOW_EDGES = 14;
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] CNT_MAX = 5'h1f;

	// timing of the reference clock and of the fastest legal shift clock
	localparam int REF_CLK_PERIOD_NS = 100;
	localparam int SCLK_MIN_PERIOD_NS = 2000;
	localparam int SCLK_MIN_HALF_CYC = SCLK_MIN_PERIOD_NS / (2 * REF_CLK_PERIOD_NS);

	// reset values of the pin synchronisers
	localparam logic SEL_N_RST = 1'b1;
	localparam logic SCLK_RST = 1'b0;

	// readout sequence, gray coded along sample, convert, lsb-first, done
	typedef enum logic [1:0] {
		ST_SAMPLE = 2'b00,
		ST_CONV = 2'b01,
		ST_LSBF = 2'b11,
		ST_DONE = 2'b10
	} adcr_state_type;

endpackage : adcr_pkg

`default_nettype wire

// *** adcr_sar_if.sv ***
// interface between the readout sequencer and the successive approximation register
`default_nettype none

interface adcr_sar_if #(
	parameter int WIDTH = 12
);
	logic start;
	logic step;
	logic comp;
	logic done;
	logic [WIDTH-1:0] trial;

	modport ctrl (output start, output step, output comp, input done, input trial);
	modport sar (input start, input step, input comp, output done, output trial);
endinterface : adcr_sar_if

`default_nettype wire

// *** adcr_sar.sv ***
// successive approximation register, one bit decision per step
`default_nettype none

module adcr_sar
	import adcr_pkg::*;
#(
	parameter int WIDTH = RES_BITS
) (
	// clock, reset, enable
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	// sequencer side
	adcr_sar_if.sar bus
);

	typedef struct packed {
		logic [WIDTH-1:0] trial;
		logic [WIDTH-1:0] mask;
		logic done;
	} adcr_sar_type;

	adcr_sar_type s_q;
	adcr_sar_type s_d;

	// start loads the msb trial; each step keeps or drops the bit under test and tries the next
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (bus.start) begin
			s_d.mask = {1'b1, {(WIDTH-1){1'b0}}};
			s_d.trial = {1'b1, {(WIDTH-1){1'b0}}};
		end else if (bus.step && (s_q.mask != '0)) begin
			s_d.trial = (bus.comp ? s_q.trial : (s_q.trial & ~s_q.mask)) | (s_q.mask >> 1);
			s_d.mask = s_q.mask >> 1;
			s_d.done = s_q.mask[0]; // last decision taken
		end
	end

	// state register, frozen while the enable is low
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s_q <= '0;
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

	assign bus.trial = s_q.trial;
	assign bus.done = s_q.done;

endmodule // adcr_sar

`default_nettype wire

// *** adcr_fifo.sv ***
// result fifo with valid and ready on both sides
`default_nettype none

module adcr_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 16
) (
	// clock, reset, enable
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	// fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);

	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
	} adcr_fifo_type;

	adcr_fifo_type s_q;
	adcr_fifo_type s_d;
	logic push;
	logic pop;

	// pointer wrap that also works for depths that are not a power of two
	function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
		ptr_next = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction

	// honest flags straight from the occupancy count
	assign in_ready_o = (s_q.cnt != (AW+1)'(DEPTH));
	assign out_valid_o = (s_q.cnt != '0);
	assign out_data_o = s_q.mem[s_q.rd];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	// simultaneous push and pop leave the count unchanged
	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.mem[s_q.wr] = in_data_i;
			s_d.wr = ptr_next(s_q.wr);
		end
		if (pop) begin
			s_d.rd = ptr_next(s_q.rd);
		end
		if (push && !pop) begin
			s_d.cnt = (AW+1)'(s_q.cnt + 1'b1);
		end else if (pop && !push) begin
			s_d.cnt = (AW+1)'(s_q.cnt - 1'b1);
		end
	end

	// state register
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s_q <= '0;
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

endmodule // adcr_fifo

`default_nettype wire

// *** adcr_readout.sv ***
// serial readout and conversion sequencing of the 12-bit sampling converter
`default_nettype none

module adcr_readout
	import adcr_pkg::*;
(
	// clock, reset, enable
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	// serial pins from and to the host
	input wire logic sclk_i,
	input wire logic select_n_i,
	output logic dout_o,
	output logic dout_oe_o,
	// analog front end
	input wire logic comp_i,
	output logic [RES_BITS-1:0] trial_code_o,
	output logic sample_pos_o,
	output logic cap_neg_o,
	// result stream
	output logic [RES_BITS-1:0] res_data_o,
	output logic res_valid_o,
	input wire logic res_ready_i,
	output logic res_room_o
);

	typedef struct packed {
		logic cs_m;
		logic cs_s;
		logic ck_m;
		logic ck_s;
		logic ck_p;
		logic cmp_m;
		logic cmp_s;
		adcr_state_type st;
		logic [CNT_W-1:0] cnt;
		logic [RES_BITS-1:0] res;
		logic dout;
		logic oe;
		logic push;
	} adcr_ctl_type;

	localparam adcr_ctl_type CTL_RST = '{
		cs_m: SEL_N_RST,
		cs_s: SEL_N_RST,
		ck_m: SCLK_RST,
		ck_s: SCLK_RST,
		ck_p: SCLK_RST,
		cmp_m: 1'b0,
		cmp_s: 1'b0,
		st: ST_SAMPLE,
		cnt: '0,
		res: '0,
		dout: 1'b0,
		oe: 1'b0,
		push: 1'b0
	};

	adcr_ctl_type s_q;
	adcr_ctl_type s_d;
	adcr_sar_if #(.WIDTH(RES_BITS)) sar_bus ();

	logic fall_w;
	logic start_w;
	logic [CNT_W-1:0] edge_w;
	logic [3:0] lsb_idx_w;
	logic lsb_bit_w;

	// slow clock assumed
	// edge detect reads only the second and third stages, never the first flop
	assign fall_w = s_q.ck_p && !s_q.ck_s;
	assign edge_w = (s_q.cnt == CNT_MAX) ? CNT_MAX : CNT_W'(s_q.cnt + 1'b1);
	assign lsb_idx_w = 4'(edge_w - CNT_W'(EDGE_LAST_MSB));
	assign lsb_bit_w = s_q.res[lsb_idx_w];

	assign start_w = fall_w && !s_q.cs_s && (s_q.st == ST_SAMPLE);

	assign sar_bus.start = start_w;
	assign sar_bus.step = fall_w && !s_q.cs_s && (s_q.st == ST_CONV);
	assign sar_bus.comp = s_q.cmp_s;

	// next state of the sequencer and of the pin synchronisers
	always_comb begin
		s_d = s_q;
		s_d.cs_m = select_n_i;
		s_d.cs_s = s_q.cs_m;
		s_d.ck_m = sclk_i;
		s_d.ck_s = s_q.ck_m;
		s_d.ck_p = s_q.ck_s;
		s_d.cmp_m = comp_i;
		s_d.cmp_s = s_q.cmp_m;
		s_d.push = 1'b0;
		if (s_q.cs_s) begin
			s_d.st = ST_SAMPLE;
			s_d.cnt = '0;
			s_d.dout = 1'b0;
			s_d.oe = 1'b0;
		end else if (fall_w) begin
			s_d.cnt = edge_w;
			case (s_q.st)
				ST_SAMPLE: begin
					s_d.oe = 1'b1;
					s_d.dout = 1'b0;
					s_d.st = ST_CONV;
				end
				ST_CONV: begin
					s_d.dout = s_q.cmp_s;
					s_d.res = {s_q.res[RES_BITS-2:0], s_q.cmp_s};
					if (edge_w == CNT_W'(EDGE_LAST_MSB)) begin
						s_d.st = ST_LSBF;
						s_d.push = 1'b1;
					end
				end
				ST_LSBF: begin
					s_d.dout = lsb_bit_w;
					if (edge_w == CNT_W'(EDGE_LAST_LSB)) begin
						s_d.st = ST_DONE;
					end
				end
				ST_DONE: begin
					s_d.dout = 1'b0;
				end
				default: begin
					s_d.st = ST_SAMPLE;
				end
			endcase
		end
	end

	// state register, frozen while the enable is low
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s_q <= CTL_RST;
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

	assign dout_o = s_q.dout;
	assign dout_oe_o = s_q.oe;

	assign sample_pos_o = (s_q.st == ST_SAMPLE);
	assign cap_neg_o = (s_q.st != ST_SAMPLE);
	assign trial_code_o = sar_bus.trial;

	// successive approximation register
	adcr_sar #(
		.WIDTH(RES_BITS)
	) u_sar (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.ce_i(ce_i),
		.bus(sar_bus)
	);

	// results also go to a stream; a full fifo drops the word but never stalls the serial pins
	adcr_fifo #(
		.WIDTH(RES_BITS),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.ce_i(ce_i),
		.in_valid_i(s_q.push),
		.in_ready_o(res_room_o),
		.in_data_i(s_q.res),
		.out_valid_o(res_valid_o),
		.out_ready_i(res_ready_i),
		.out_data_o(res_data_o)
	);

	// checks on the sequencer, all in the reference clock domain
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	sequence s_first_edge;
		ce_i && start_w;
	endsequence

	sequence s_null_out;
		dout_oe_o && !dout_o && cap_neg_o && !sample_pos_o;
	endsequence

	a_deselect_release:
		assert property (ce_i && s_q.cs_s |=> !dout_oe_o && sample_pos_o && !cap_neg_o)
		else $error("deselect did not return to sampling with output released");

	a_first_pulse_null:
		assert property (s_first_edge |=> s_null_out)
		else $error("first shift pulse did not enable output with null bit");

	a_out_on_fall:
		assert property ($changed(dout_o) && dout_oe_o |-> $past(fall_w))
		else $error("output bit changed without a shift clock falling edge");

	a_cap_once:
		assert property ($fell(cap_neg_o) |-> $past(s_q.cs_s))
		else $error("capacitor returned to positive input while selected");

	a_hold_on_edge:
		assert property ($rose(cap_neg_o) |-> $past(start_w))
		else $error("hold entered without the starting falling edge");

	a_conv_length:
		assert property (sar_bus.done |-> s_q.st == ST_LSBF && s_q.cnt == CNT_W'(EDGE_LAST_MSB))
		else $error("conversion did not end on the twelfth decision");

	a_msb_bit:
		assert property (ce_i && sar_bus.step |=> dout_o == $past(s_q.cmp_s) && dout_oe_o)
		else $error("msb-first bit differs from the comparator decision");

	a_lsb_bit:
		assert property (ce_i && fall_w && !s_q.cs_s && s_q.st == ST_LSBF |=> dout_o == $past(lsb_bit_w))
		else $error("lsb-first bit differs from the held result");

	a_push_current:
		assert property (s_q.push |-> sar_bus.done && s_q.res == $past(s_d.res))
		else $error("queued result is not from the current conversion");

	// further checks on the driver enable, the approximation register and the result
	sequence s_done_fall;
		ce_i && fall_w && !s_q.cs_s && (s_q.st == ST_DONE);
	endsequence

	a_oe_rise_start:
		assert property ($rose(dout_oe_o) |-> $past(start_w))
		else $error("output driver enabled without a selected first pulse");

	a_oe_holds:
		assert property (dout_oe_o && !s_q.cs_s |=> dout_oe_o)
		else $error("output driver dropped while still selected");

	a_cap_active:
		assert property (cap_neg_o |-> dout_oe_o)
		else $error("capacitor on negative input outside an active transfer");

	a_sample_holds:
		assert property (sample_pos_o && !fall_w |=> sample_pos_o)
		else $error("sampling ended without a shift clock falling edge");

	a_sar_load:
		assert property (s_first_edge |=> trial_code_o == {1'b1, {(RES_BITS-1){1'b0}}})
		else $error("first trial code is not the midscale value");

	a_trial_steady:
		assert property (!sar_bus.start && !sar_bus.step |=> $stable(trial_code_o))
		else $error("trial code moved without a decision");

	a_hold_count:
		assert property (s_first_edge |=> s_q.cnt == CNT_W'(EDGE_HOLD))
		else $error("edge count wrong after the hold edge");

	a_push_single:
		assert property (s_q.push |=> !s_q.push)
		else $error("one conversion queued twice");

	a_push_at_done:
		assert property (sar_bus.done |-> s_q.push)
		else $error("finished conversion not queued");

	a_res_frozen:
		assert property (s_q.st != ST_CONV |=> $stable(s_q.res))
		else $error("result changed outside conversion");

	a_tail_zero:
		assert property (s_done_fall |=> !dout_o && dout_oe_o)
		else $error("trailing shift clock did not give a zero bit");

endmodule // adcr_readout

`default_nettype wire

// *** adcr_host_model.sv ***
// host side model: select, shift clock, bit capture and the comparator
`default_nettype none

module adcr_host_model
	import adcr_pkg::*;
(
	// clock
	input wire logic ref_clk_i,
	// serial pins
	output logic sclk_o,
	output logic select_n_o,
	input wire logic dout_i,
	input wire logic dout_oe_i,
	// analog front end
	input wire logic [RES_BITS-1:0] trial_code_i,
	output logic comp_o
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [RES_BITS-1:0] vin_q = '0;

	// comparator keeps the trial bit while the held input reaches it
	assign comp_o = (vin_q >= trial_code_i);

	// idle: deselected, shift clock parked low so no stray edge is seen
	initial begin
		sclk_o = 1'b0;
		select_n_o = 1'b1;
	end

	// one frame of nfalls shift clocks, half period in reference cycles
	task automatic frame(input logic [RES_BITS-1:0] vin, input int nfalls, input int half,
		output logic [31:0] bits, output int oe_low);
		bits = '0;
		oe_low = 0;
		vin_q = vin;
		@(negedge ref_clk_i) select_n_o = 1'b0;
		repeat (half) @(negedge ref_clk_i);
		for (int k = 1; k <= nfalls; k++) begin
			// half period of at least ten cycles
			sclk_o = 1'b1;
			repeat (half) @(negedge ref_clk_i);
			sclk_o = 1'b0;
			repeat (half) @(negedge ref_clk_i);
			// bit taken at the following rise
			bits[k-1] = dout_i;
			if (dout_oe_i !== 1'b1) oe_low++;
		end
		// frame length chosen by caller, at least 13 for a result
		select_n_o = 1'b1;
		repeat (2 * half) @(negedge ref_clk_i);
	endtask
endmodule : adcr_host_model

`default_nettype wire

// *** adc_serial_readout_control_bench.sv ***
// self-checking bench of the converter readout control
`default_nettype none

module adc_serial_readout_control_bench
	import adcr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic res_ready = 1'b0;
	logic sclk, select_n, dout, dout_oe, comp, sample_pos, cap_neg, cap_q, res_valid, res_room;
	logic [RES_BITS-1:0] trial, res_data;
	logic [31:0] model_q[$];
	int n_mismatch = 0;
	int n_tests = 0;
	int rises = 0;
	int cycles = 0;
	// pin to state latency: two synchroniser stages plus the edge stage
	localparam int SYNC_LAT = 3;
	logic sel_q = 1'b1;
	int sel_cyc = 0;
	int win = 0;

	adcr_readout adcr_readout_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
		.sclk_i(sclk), .select_n_i(select_n), .dout_o(dout), .dout_oe_o(dout_oe),
		.comp_i(comp), .trial_code_o(trial), .sample_pos_o(sample_pos), .cap_neg_o(cap_neg),
		.res_data_o(res_data), .res_valid_o(res_valid), .res_ready_i(res_ready), .res_room_o(res_room));

	adcr_host_model adcr_host_model_i (.ref_clk_i(ref_clk_i), .sclk_o(sclk), .select_n_o(select_n),
		.dout_i(dout), .dout_oe_i(dout_oe), .trial_code_i(trial), .comp_o(comp));

	// 10 MHz reference clock
	always #50 ref_clk_i = ~ref_clk_i;

	// count capacitor moves and cut a hang short
	always @(posedge ref_clk_i) begin
		cap_q <= cap_neg;
		sel_q <= select_n;
		if (select_n === 1'b0 && sel_q === 1'b1) sel_cyc = cycles;
		if (cap_neg === 1'b1 && cap_q === 1'b0) begin
			rises++;
			win = cycles - sel_cyc;
		end
		cycles++;
		if (cycles == 60000) begin
			n_mismatch++;
			complete_run();
		end
	end

	task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_flag(input string what, input logic exp, input logic got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %b seen %b", what, exp, got);
		end
	endtask

	// one frame, serial bits checked against the model, word queued if complete
	task automatic xfer(input int nfalls, input logic [RES_BITS-1:0] vin);
		logic [31:0] bits, exp;
		int oe_low;
		int half;
		exp = '0;
		rises = 0;
		half = 10 + $urandom % 4;
		adcr_host_model_i.frame(vin, nfalls, half, bits, oe_low);
		for (int k = 2; k <= 24; k++) exp[k-1] = (k <= 13) ? vin[13-k] : vin[k-13];
		exp &= (32'h1 << nfalls) - 32'h1;
		check_word("frame bits", exp, bits);
		check_word("oe low captures", 32'h0, 32'(oe_low));
		check_word("capacitor moves", 32'h1, 32'(rises));
		// sampling ends at the first shift clock fall, one shift period after select falls
		check_word("sample window", 32'(2 * half + SYNC_LAT), 32'(win));
		check_flag("oe after deselect", 1'b0, dout_oe);
		check_flag("sampling again", 1'b1, sample_pos);
		if (nfalls >= 13 && model_q.size() < FIFO_DEPTH) model_q.push_back(32'(vin));
	endtask

	// drain with random stalls until the model is empty
	task automatic drain();
		int guard;
		guard = 0;
		while (model_q.size() > 0 && guard < 400) begin
			@(negedge ref_clk_i);
			guard++;
			res_ready = (res_valid === 1'b1) && ($urandom % 2 == 1);
			if (res_ready) check_word("word", model_q.pop_front(), 32'(res_data));
		end
		@(negedge ref_clk_i) res_ready = 1'b0;
		check_flag("fifo empty", 1'b0, res_valid);
		check_word("words left", 32'h0, 32'(model_q.size()));
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// main sequence
	initial begin
		void'($urandom(43275));
		repeat (10) @(negedge ref_clk_i);
		sys_rst_i = 1'b0;
		repeat (3) @(negedge ref_clk_i);
		check_flag("room after reset", 1'b1, res_room);
		check_flag("valid after reset", 1'b0, res_valid);
		// boundary codes, trailing zeros, an aborted frame, then a fresh one
		xfer(26, 12'h000);
		xfer(24, 12'hfff);
		xfer(24, RES_BITS'($urandom));
		xfer(5, 12'h5a5);
		xfer(14, RES_BITS'($urandom));
		drain();
		// fill until the fifo refuses, one more dropped, then drain
		for (int i = 0; i <= FIFO_DEPTH; i++) xfer(14, RES_BITS'($urandom));
		check_flag("room when full", 1'b0, res_room);
		drain();
		complete_run();
	end
endmodule : adc_serial_readout_control_bench

`default_nettype wire
